// ===== logic/msh_ctrl.sv
// control core: serial intake, channel codes, reset/track pin, acquisition
`timescale 1ns/1ps
// How it works
// - converter write stores 14-bit code into the one addressed channel
// - once address and code are in, the addressed channel updates
// - power-on clears all 33 channel codes including offset channel
// - low pulse 90 to 200 ns on track/reset pin resets everything
// - low pulse shorter than 90 ns is a glitch and changes nothing
// - low longer than 200 ns tracks: analog input drives selected output
// - acquisition waits while tracking and starts on the pin rising edge
// - during acquisition the output buffer is fed from the analog input
// - acquisition ends within 16 us, then output switches to new code
// - acquired code holds until the same channel is addressed again or a reset pulse clears it
// - busy_n is low exactly while an acquisition runs
// - offset channel is set by acquisition or by a direct code write
// - first two word bits: acquire, write, acquire-readback, readback
// - offset select bit targets offset channel and ignores address bits
// - with pin high, acquisition starts as soon as channel is addressed
module msh_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   input wire logic track_or_reset_n,
   input wire logic [msh_pkg::CODE_W-1:0] adc_code,
   output logic busy_n,
   output logic [msh_pkg::NUM_CH*msh_pkg::CODE_W-1:0] channel_code,
   output logic [msh_pkg::CODE_W-1:0] offset_code,
   output logic [msh_pkg::NUM_REGS-1:0] out_from_vin,
   output logic soft_reset_pulse
);
   logic sclk_s;
   logic sync_n_s;
   logic din_s;
   logic trk_s;
   logic sclk_prev_q;
   logic trk_prev_q;
   logic [23:0] shift_q;
   logic [4:0] bit_cnt_q;
   logic [9:0] hdr_q;
   logic [3:0] low_cnt_q;
   logic soft_rst;
   logic tracking;
   logic sclk_fall;
   logic trk_rise;
   logic hdr_done;
   logic word_done;
   logic [9:0] hdr_now;
   logic [msh_pkg::CODE_W-1:0] code_now;
   logic [5:0] hdr_idx;
   logic acq_req;
   logic wr_req;
   logic [5:0] sel_ch_q;
   logic [5:0] acq_ch_q;
   logic [8:0] acq_cnt_q;
   msh_pkg::msh_acq_e acq_state_q;
   logic [msh_pkg::CODE_W-1:0] code_q [0:msh_pkg::NUM_REGS-1];

   // pins come from outside ref_clk; idle levels high for the strobes
   msh_sync #(
      .WIDTH(4),
      .INIT(4'hd)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in({sclk, sync_n, din, track_or_reset_n}),
      .sync_out({sclk_s, sync_n_s, din_s, trk_s})
   );

   // edge history of the synchronised pins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclk_prev_q <= 1'b1;
         trk_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_s;
         trk_prev_q <= trk_s;
      end
   end

   assign sclk_fall = sclk_prev_q & ~sclk_s & ~sync_n_s;
   assign trk_rise = ~trk_prev_q & trk_s;

   // low-time counter saturates one past the upper limit
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         low_cnt_q <= 4'h0;
      end else if (trk_s) begin
         low_cnt_q <= 4'h0;
      end else if (low_cnt_q <= msh_pkg::RST_MAX_CYC) begin
         low_cnt_q <= low_cnt_q + 4'h1;
      end
   end

   // a pulse inside the window resets; shorter ones are dropped as glitches
   assign soft_rst = trk_rise && (low_cnt_q >= msh_pkg::RST_MIN_CYC)
      && (low_cnt_q <= msh_pkg::RST_MAX_CYC);
   assign tracking = ~trk_s && (low_cnt_q > msh_pkg::RST_MAX_CYC);
   assign soft_reset_pulse = soft_rst;

   // data is taken on sclk falling edges while the frame is open
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shift_q <= 24'h000000;
         bit_cnt_q <= 5'h00;
         hdr_q <= 10'h000;
      end else if (soft_rst || sync_n_s) begin
         bit_cnt_q <= 5'h00;
      end else if (sclk_fall) begin
         shift_q <= {shift_q[22:0], din_s};
         if (bit_cnt_q != msh_pkg::WORD_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
         if (hdr_done) begin
            hdr_q <= hdr_now;
         end
      end
   end

   assign hdr_now = {shift_q[8:0], din_s};
   // code field is the last fourteen bits, completed by the bit now arriving
   assign code_now = {shift_q[12:0], din_s};
   assign hdr_done = sclk_fall && (bit_cnt_q == msh_pkg::HDR_BITS - 5'h01);
   assign word_done = sclk_fall
      && (bit_cnt_q == msh_pkg::WORD_BITS - 5'h01);
   // offset select overrides the five address bits
   assign hdr_idx = hdr_now[msh_pkg::HDR_OFFSET_SEL]
      ? msh_pkg::OFFSET_IDX
      : {1'b0, hdr_now[msh_pkg::HDR_ADDR_HI:msh_pkg::HDR_ADDR_LO]};
   // acquire modes act on the header alone; readback only is not handled here
   assign acq_req = hdr_done && !soft_rst
      && ((hdr_now[msh_pkg::HDR_MODE_HI:msh_pkg::HDR_MODE_LO]
           == msh_pkg::MODE_SH_ACQ)
          || (hdr_now[msh_pkg::HDR_MODE_HI:msh_pkg::HDR_MODE_LO]
              == msh_pkg::MODE_ACQ_RB));
   assign wr_req = word_done && !soft_rst
      && (hdr_q[msh_pkg::HDR_MODE_HI:msh_pkg::HDR_MODE_LO]
          == msh_pkg::MODE_WRITE);

   // selected channel follows the latest acquire-mode address
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sel_ch_q <= 6'h00;
      end else if (soft_rst) begin
         sel_ch_q <= 6'h00;
      end else if (acq_req) begin
         sel_ch_q <= hdr_idx;
      end
   end

   // acquisition sequencer; a new address restarts any acquisition in flight
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acq_state_q <= msh_pkg::ACQ_IDLE;
         acq_ch_q <= 6'h00;
         acq_cnt_q <= 9'h000;
      end else if (soft_rst) begin
         acq_state_q <= msh_pkg::ACQ_IDLE;
         acq_ch_q <= 6'h00;
         acq_cnt_q <= 9'h000;
      end else if (acq_req) begin
         acq_ch_q <= hdr_idx;
         acq_cnt_q <= 9'h000;
         // pin low: could still be a reset pulse, so busy must wait
         if (trk_s) begin
            acq_state_q <= msh_pkg::ACQ_RUN;
         end else begin
            acq_state_q <= msh_pkg::ACQ_PEND;
         end
      end else begin
         case (acq_state_q)
            msh_pkg::ACQ_PEND: begin
               if (trk_rise) begin
                  acq_state_q <= msh_pkg::ACQ_RUN;
               end
            end
            msh_pkg::ACQ_RUN: begin
               if (acq_cnt_q == msh_pkg::ACQ_CYC - 9'h001) begin
                  acq_state_q <= msh_pkg::ACQ_IDLE;
               end else begin
                  acq_cnt_q <= acq_cnt_q + 9'h001;
               end
            end
            msh_pkg::ACQ_IDLE: begin
               acq_state_q <= msh_pkg::ACQ_IDLE;
            end
            default: begin
               acq_state_q <= msh_pkg::ACQ_IDLE;
            end
         endcase
      end
   end

   // busy_n low for exactly the run state; fixed length keeps it predictable
   assign busy_n = (acq_state_q != msh_pkg::ACQ_RUN);

   // channel code store; writes and acquisitions never collide in practice,
   // but a write is given priority since it carries an explicit code
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < msh_pkg::NUM_REGS; i++) begin
            code_q[i] <= msh_pkg::CODE_RESET;
         end
      end else if (soft_rst) begin
         for (int i = 0; i < msh_pkg::NUM_REGS; i++) begin
            code_q[i] <= msh_pkg::CODE_RESET;
         end
      end else if (wr_req) begin
         if (hdr_q[msh_pkg::HDR_OFFSET_SEL]) begin
            code_q[msh_pkg::NUM_REGS-1] <= code_now;
         end else begin
            code_q[hdr_q[msh_pkg::HDR_ADDR_HI:msh_pkg::HDR_ADDR_LO]]
               <= code_now;
         end
      end else if (acq_state_q == msh_pkg::ACQ_RUN && !acq_req
                   && acq_cnt_q == msh_pkg::ACQ_CYC - 9'h001) begin
         code_q[acq_ch_q] <= adc_code;
      end
   end

   // per-channel outputs and analog-input routing
   genvar g;
   generate
      for (g = 0; g < msh_pkg::NUM_REGS; g++) begin : g_ch
         if (g < msh_pkg::NUM_CH) begin : g_out
            assign channel_code[g*msh_pkg::CODE_W +: msh_pkg::CODE_W]
               = code_q[g];
         end
         assign out_from_vin[g] =
            ((acq_state_q == msh_pkg::ACQ_RUN) && (acq_ch_q == 6'(g)))
            || (tracking && (sel_ch_q == 6'(g)));
      end
   endgenerate

   assign offset_code = code_q[msh_pkg::NUM_REGS-1];
endmodule : msh_ctrl

// ===== logic/msh_pkg.sv
// constants for the multichannel sample-and-hold converter control block
package msh_pkg;
   localparam int CODE_W = 14;          // converter code width
   localparam int NUM_CH = 32;          // ordinary output channels
   localparam int NUM_REGS = 33;        // channels plus the offset channel
   localparam int ADDR_W = 5;
   localparam logic [5:0] OFFSET_IDX = 6'h20;
   localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
   // serial word layout, msb first
   localparam logic [4:0] HDR_BITS = 5'h0a;   // mode, cal, offset, test, addr
   localparam logic [4:0] WORD_BITS = 5'h18;  // header plus code bits
   localparam int HDR_MODE_HI = 9;
   localparam int HDR_MODE_LO = 8;
   localparam int HDR_CAL = 7;
   localparam int HDR_OFFSET_SEL = 6;
   localparam int HDR_TEST = 5;
   localparam int HDR_ADDR_HI = 4;
   localparam int HDR_ADDR_LO = 0;
   // operation selected by the two mode bits
   localparam logic [1:0] MODE_SH_ACQ = 2'h0;
   localparam logic [1:0] MODE_WRITE = 2'h1;
   localparam logic [1:0] MODE_ACQ_RB = 2'h2;
   localparam logic [1:0] MODE_RB = 2'h3;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int RST_MIN_NS = 90;
   localparam int RST_MAX_NS = 200;
   localparam int ACQ_MAX_NS = 16000;   // 16 us acquisition limit
   localparam int RST_MIN_CYC_I =
      (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_MAX_CYC_I = RST_MAX_NS / CLK_PERIOD_NS;
   localparam int ACQ_CYC_I = ACQ_MAX_NS / CLK_PERIOD_NS;
   localparam logic [3:0] RST_MIN_CYC = 4'(RST_MIN_CYC_I);
   localparam logic [3:0] RST_MAX_CYC = 4'(RST_MAX_CYC_I);
   localparam logic [8:0] ACQ_CYC = 9'(ACQ_CYC_I);
   typedef enum logic [1:0] {
      ACQ_IDLE = 2'b00,
      ACQ_PEND = 2'b01,
      ACQ_RUN = 2'b10
   } msh_acq_e;
endpackage : msh_pkg

// ===== logic/msh_sync.sv
// two-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
module msh_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_q <= INIT;
         sync_out <= INIT;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : msh_sync

// ===== test/msh_ctrl_properties.sv
// assertion checker for the sample-and-hold converter control block
`timescale 1ns/1ps
module msh_ctrl_properties (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sync_n,
   input wire logic track_or_reset_n,
   input wire logic busy_n,
   input wire logic [msh_pkg::NUM_CH*msh_pkg::CODE_W-1:0] channel_code,
   input wire logic [msh_pkg::CODE_W-1:0] offset_code,
   input wire logic [msh_pkg::NUM_REGS-1:0] out_from_vin,
   input wire logic soft_reset_pulse
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic [9:0] low_q;
   logic [3:0] trk_q;
   // length of the current busy run, so the end can be checked exactly
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) low_q <= 10'h000;
      else low_q <= busy_n ? 10'h000 : low_q + 10'h001;
   end
   // raw low time of the track pin; saturates so long tracks stay flagged
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) trk_q <= 4'h0;
      else if (track_or_reset_n) trk_q <= 4'h0;
      else if (trk_q != 4'hf) trk_q <= trk_q + 4'h1;
   end
   AST_POR_CLEAR: assert property ($fell(rst) |-> busy_n &&
      channel_code == '0 && offset_code == '0) else $error("not clear");
   AST_ACQ_LEN: assert property ($rose(busy_n) &&
      !soft_reset_pulse && !$past(soft_reset_pulse)
      |-> low_q == 10'h190) else $error("busy len");
   AST_BUSY_VIN: assert property (!busy_n |-> |out_from_vin)
      else $error("output not on input while busy");
   AST_RST_WIN: assert property ($rose(track_or_reset_n) &&
      trk_q >= 4'h3 && trk_q <= 4'h5 |-> ##[1:6] soft_reset_pulse)
      else $error("reset pulse missed");
   AST_GLITCH: assert property ($rose(track_or_reset_n) &&
      trk_q < 4'h3 |-> !soft_reset_pulse [*6]) else $error("glitch reset");
   AST_RST_CLEAR: assert property (soft_reset_pulse |=> busy_n &&
      channel_code == '0 && offset_code == '0) else $error("reset effect");
   AST_TRACK_VIN: assert property (trk_q > 4'h9
      |-> |out_from_vin) else $error("track not routed");
   AST_HOLD: assert property (busy_n && $past(busy_n) && sync_n &&
      $past(sync_n, 6) && !soft_reset_pulse && !$past(soft_reset_pulse)
      |-> $stable(channel_code) && $stable(offset_code)) else $error("drift");
   COV_ACQ: cover property ($rose(busy_n));
   COV_RST: cover property (soft_reset_pulse);
   COV_TRK: cover property (trk_q == 4'hf);
endmodule : msh_ctrl_properties
bind msh_ctrl msh_ctrl_properties i_props (.ref_clk(ref_clk), .rst(rst),
   .sync_n(sync_n), .track_or_reset_n(track_or_reset_n), .busy_n(busy_n),
   .channel_code(channel_code), .offset_code(offset_code),
   .out_from_vin(out_from_vin), .soft_reset_pulse(soft_reset_pulse));

// ===== test/msh_host_model.sv
// host model: drives the three-wire serial link of the converter block
`timescale 1ns/1ps
module msh_host_model (
   output logic sclk,
   output logic sync_n,
   output logic din
);
   // idle link: clock parked high, frame closed, data at its pull-up
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      din = 1'b1;
   end
   // top n bits of w, msb first, data changes only while the clock is high
   task send(input logic [23:0] w, input int n);
      int i;
      sync_n = 1'b0;
      for (i = 23; i > 23 - n; i--) begin
         din = w[i];
         #160 sclk = 1'b0;
         #160 sclk = 1'b1;
      end
      #160 sync_n = 1'b1;
      din = 1'b1;
   endtask : send
endmodule : msh_host_model

// ===== test/test_msh_ctrl.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_msh_ctrl;
   logic ref_clk, rst, trk_n, busy_n, srp;
   wire sclk, sync_n, din;
   logic [msh_pkg::CODE_W-1:0] adc, off_code;
   logic [msh_pkg::NUM_CH*msh_pkg::CODE_W-1:0] ch_code;
   logic [msh_pkg::NUM_REGS-1:0] from_vin;
   logic [13:0] expv [33];
   int miscompares, comparisons, cycles, n, k;
   msh_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
      .sync_n(sync_n), .din(din), .track_or_reset_n(trk_n), .adc_code(adc),
      .busy_n(busy_n), .channel_code(ch_code), .offset_code(off_code),
      .out_from_vin(from_vin), .soft_reset_pulse(srp));
   msh_host_model i_host (.sclk(sclk), .sync_n(sync_n), .din(din));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // hang guard, well above the few thousand cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done;
      end
   end
   task test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   task chk(input logic [31:0] got, input logic [31:0] want);
      comparisons++;
      if (got !== want) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, got, want);
      end
   endtask : chk
   task chk_all;
      for (k = 0; k < 32; k++) chk(ch_code[14*k +: 14], expv[k]);
      chk(off_code, expv[32]);
   endtask : chk_all
   // every step lands 1 ns after an edge so inputs never race the clock
   task cyc(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask : cyc
   task wt(input logic v);
      n = 0;
      while (busy_n !== v && n < 1000) begin
         cyc(1);
         n++;
      end
   endtask : wt
   function automatic logic [23:0] wd(input logic [1:0] m, input logic o,
      input logic [4:0] a, input logic [13:0] c);
      return {m, 1'b0, o, 1'b0, a, c};
   endfunction : wd
   task wr(input logic o, input logic [4:0] a, input logic [13:0] c);
      i_host.send(wd(2'h1, o, a, c), 24);
      cyc(8);
      if (o) expv[32] = c;
      else expv[a] = c;
   endtask : wr
   task acq(input logic [1:0] m, input logic o, input logic [4:0] a,
      input logic [13:0] c);
      int idx;
      idx = o ? 32 : a;
      adc = c;
      i_host.send(wd(m, o, a, 14'h0000), 10);
      wt(1'b0);
      chk(busy_n, 1'b0);
      chk(from_vin[idx], 1'b1);
      wt(1'b1);
      chk(from_vin[idx], 1'b0);
      expv[idx] = c;
      chk_all;
   endtask : acq
   task t_write;
      wr(1'b0, 5'h00, 14'h3fff);
      wr(1'b0, 5'h1f, 14'h2a55);
      wr(1'b1, 5'h03, 14'h1234);
      chk_all;
      i_host.send(wd(2'h3, 1'b0, 5'h1f, 14'h0000), 10);
      cyc(8);
      chk_all;
   endtask : t_write
   task t_track;
      trk_n = 1'b0;
      cyc(20);
      i_host.send(wd(2'h0, 1'b0, 5'h07, 14'h0000), 10);
      cyc(4);
      chk(busy_n, 1'b1);
      chk(from_vin[7], 1'b1);
      adc = 14'h0777;
      trk_n = 1'b1;
      wt(1'b0);
      chk(busy_n, 1'b0);
      wt(1'b1);
      expv[7] = 14'h0777;
      cyc(30);
      chk_all;
   endtask : t_track
   task t_reset;
      trk_n = 1'b0;
      cyc(2);
      trk_n = 1'b1;
      cyc(10);
      chk_all;
      trk_n = 1'b0;
      cyc(4);
      trk_n = 1'b1;
      n = 0;
      repeat (10) begin
         cyc(1);
         if (srp === 1'b1) n++;
      end
      chk(n, 1);
      chk(busy_n, 1'b1);
      for (k = 0; k < 33; k++) expv[k] = 14'h0000;
      chk_all;
   endtask : t_reset
   initial begin
      rst = 1'b1;
      trk_n = 1'b1;
      adc = 14'h0000;
      for (k = 0; k < 33; k++) expv[k] = 14'h0000;
      repeat (8) @(posedge ref_clk);
      #1 rst = 1'b0;
      cyc(4);
      chk_all;
      t_write;
      acq(2'h0, 1'b0, 5'h05, 14'h0abc);
      acq(2'h2, 1'b1, 5'h09, 14'h1555);
      t_track;
      t_reset;
      test_done;
   end
endmodule : test_msh_ctrl
